/* File: logic/srrx_core.v */
// return-from-subroutine and rotate-left-through-carry executor
//
// How it works
// RULE1: return opcode pops the stack; popped top value loads program counter.
// RULE2: shadow bit set restores work, flags and bank select from shadows.
// RULE3: shadow bit clear leaves work, flags and bank select untouched.
// RULE4: return never touches the upper and high program counter latches.
// RULE5: rotate shifts byte left, old bit7 to carry, carry to bit0; C N Z.
// RULE6: destination bit zero writes work register, one writes file register.
// RULE7: access bit zero uses access bank, one uses bank select register.
// RULE8: access zero with extended set and operand <= 95 uses indexed offset.
// RULE9: return takes two cycles: pop in last quarter, then an idle cycle.
// RULE10: rotate takes one cycle: decode, read, process, write in quarters.
`timescale 1ns/10ps
`default_nettype none
`include "srrx_consts.vh"
module srrx_core #(
	parameter PCW = 21,
	parameter AW = 12
) (
	input wire clock_i,
	input wire nrst_i,
	input wire ce_i,
	input wire [15:0] instr_i,
	input wire instr_valid_i,
	input wire ext_set_en_i,
	input wire [AW-1:0] index_base_i,
	input wire [PCW-1:0] stack_top_value_i,
	input wire [7:0] shadow_work_reg_i,
	input wire [7:0] shadow_flags_reg_i,
	input wire [3:0] shadow_bank_select_i,
	input wire [7:0] pc_upper_latch_i,
	input wire [7:0] pc_high_latch_i,
	output reg [PCW-1:0] pc_o,
	output reg stack_pop_o,
	output reg [7:0] work_o,
	output reg [7:0] flags_o,
	output reg [3:0] bank_select_register_o,
	output reg [7:0] pc_upper_latch_o,
	output reg [7:0] pc_high_latch_o,
	output reg [1:0] quarter_o,
	output reg busy_o,
	output reg file_we_o,
	output reg [AW-1:0] file_addr_o,
	output reg [7:0] file_wdata_o
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	localparam ST_IDLE = 2'h0;
	localparam ST_ROT = 2'h1;
	localparam ST_RET = 2'h2;
	localparam ST_NOP = 2'h3;

	reg [1:0] state;
	reg [1:0] quarter;
	reg [15:0] opcode;
	reg [AW-1:0] eff_addr;
	reg [7:0] result;
	reg carry_out;
	wire [7:0] rd_data;
	reg next_we;
	reg [AW-1:0] next_addr;

	// ------------------------------------------------------------
	// opcode decode
	// ------------------------------------------------------------
	wire is_ret;
	wire is_rot;
	assign is_ret = ((instr_i & `SRRX_RET_MASK) == `SRRX_RET_OPC); // RULE1
	assign is_rot =
		(instr_i[`SRRX_ROT_TOP:`SRRX_ROT_BOT] == `SRRX_ROT_OPC); // RULE5

	// ------------------------------------------------------------
	// operand address
	// ------------------------------------------------------------
	reg [AW-1:0] dec_addr;
	always @*
	begin
		dec_addr = {AW{1'b0}};
		if (instr_i[`SRRX_ACCESS_BIT]) // RULE7
			dec_addr = {bank_select_register_o, instr_i[7:0]};
		else if (ext_set_en_i && instr_i[7:0] <= `SRRX_IDX_LIMIT) // RULE8
			dec_addr = index_base_i + {{(AW-8){1'b0}}, instr_i[7:0]};
		else if (instr_i[7:0] < `SRRX_ACC_SPLIT) // RULE7
			dec_addr = {`SRRX_BANK_RST, instr_i[7:0]};
		else
			dec_addr = {`SRRX_ACC_HIGH_BANK, instr_i[7:0]};
	end

	// ------------------------------------------------------------
	// data memory
	// ------------------------------------------------------------
	srrx_file_mem #(
		.AW(AW),
		.DW(8)
	) u_mem (
		.clock_i(clock_i),
		.ce_i(ce_i),
		.raddr_i(eff_addr),
		.rdata_o(rd_data),
		.we_i(next_we),
		.waddr_i(next_addr),
		.wdata_i(result)
	);

	// ------------------------------------------------------------
	// rotate datapath
	// ------------------------------------------------------------
	// registered read data is valid from quarter 3; the write lands
	// before the next take reads, so a repeat on one byte sees it
	always @*
	begin
		result = {rd_data[6:0], flags_o[`SRRX_FLAG_C]}; // RULE5
		carry_out = rd_data[7]; // RULE5
		next_we = 1'b0;
		next_addr = eff_addr;
		if (state == ST_ROT && quarter == `SRRX_Q4)
			next_we = opcode[`SRRX_DEST_BIT]; // RULE6
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state <= ST_IDLE;
			quarter <= `SRRX_Q1;
			opcode <= 16'h0000;
			eff_addr <= {AW{1'b0}};
			pc_o <= `SRRX_PC_RST;
			stack_pop_o <= 1'b0;
			work_o <= `SRRX_BYTE_RST;
			flags_o <= `SRRX_BYTE_RST;
			bank_select_register_o <= `SRRX_BANK_RST;
			pc_upper_latch_o <= `SRRX_BYTE_RST;
			pc_high_latch_o <= `SRRX_BYTE_RST;
			quarter_o <= `SRRX_Q1;
			busy_o <= 1'b0;
			file_we_o <= 1'b0;
			file_addr_o <= {AW{1'b0}};
			file_wdata_o <= `SRRX_BYTE_RST;
		end
		else if (ce_i)
		begin
			quarter <= quarter + 2'h1;
			quarter_o <= quarter + 2'h1;
			stack_pop_o <= 1'b0;
			file_we_o <= next_we;
			file_addr_o <= next_addr;
			file_wdata_o <= result;
			case (state)
			ST_IDLE:
			begin
				// latches mirror software writes; return never loads them
				pc_upper_latch_o <= pc_upper_latch_i; // RULE4
				pc_high_latch_o <= pc_high_latch_i; // RULE4
				if (quarter == `SRRX_Q1 && instr_valid_i)
				begin
					opcode <= instr_i;
					eff_addr <= dec_addr;
					if (is_ret)
					begin
						state <= ST_RET;
						busy_o <= 1'b1;
					end
					else if (is_rot)
					begin
						state <= ST_ROT; // RULE10
						busy_o <= 1'b1;
					end
				end
			end
			ST_ROT:
			begin
				if (quarter == `SRRX_Q4) // RULE10
				begin
					flags_o[`SRRX_FLAG_C] <= carry_out; // RULE5
					flags_o[`SRRX_FLAG_N] <= result[7]; // RULE5
					flags_o[`SRRX_FLAG_Z] <= (result == 8'h00); // RULE5
					if (!opcode[`SRRX_DEST_BIT])
						work_o <= result; // RULE6
					state <= ST_IDLE;
					busy_o <= 1'b0;
				end
			end
			ST_RET:
			begin
				if (quarter == `SRRX_Q4) // RULE9
				begin
					pc_o <= stack_top_value_i; // RULE1
					stack_pop_o <= 1'b1; // RULE1
					// shadow clear: no write to work, flags or bank select; pc still loads
					if (opcode[`SRRX_SHADOW_BIT]) // RULE2 RULE3
					begin
						work_o <= shadow_work_reg_i; // RULE2
						flags_o <= shadow_flags_reg_i; // RULE2
						bank_select_register_o <= shadow_bank_select_i; // RULE2
					end
					state <= ST_NOP;
				end
			end
			ST_NOP:
			begin
				// flush cycle while the fetch refills from the new pc
				if (quarter == `SRRX_Q4) // RULE9
				begin
					state <= ST_IDLE;
					busy_o <= 1'b0;
				end
			end
			default:
			begin
				state <= ST_IDLE;
				busy_o <= 1'b0;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: logic/srrx_consts.vh */
// constants for the return and rotate execution block
`ifndef SRRX_CONSTS_VH
`define SRRX_CONSTS_VH
// opcode matching
`define SRRX_RET_OPC 16'h0012
`define SRRX_RET_MASK 16'hfffe
`define SRRX_ROT_OPC 6'h0d
`define SRRX_ROT_TOP 15
`define SRRX_ROT_BOT 10
// field positions
`define SRRX_SHADOW_BIT 0
`define SRRX_DEST_BIT 9
`define SRRX_ACCESS_BIT 8
// status flag positions
`define SRRX_FLAG_C 0
`define SRRX_FLAG_Z 2
`define SRRX_FLAG_N 4
// indexed literal offset limit
`define SRRX_IDX_LIMIT 8'h5f
// access bank split and its upper bank
`define SRRX_ACC_SPLIT 8'h60
`define SRRX_ACC_HIGH_BANK 4'hf
// quarter counts
`define SRRX_Q1 2'h0
`define SRRX_Q2 2'h1
`define SRRX_Q3 2'h2
`define SRRX_Q4 2'h3
// reset values
`define SRRX_PC_RST 21'h000000
`define SRRX_BYTE_RST 8'h00
`define SRRX_BANK_RST 4'h0
`endif

/* File: logic/srrx_file_mem.v */
// small data memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module srrx_file_mem #(
	parameter AW = 12,
	parameter DW = 8
) (
	input wire clock_i,
	input wire ce_i,
	input wire [AW-1:0] raddr_i,
	output reg [DW-1:0] rdata_o,
	input wire we_i,
	input wire [AW-1:0] waddr_i,
	input wire [DW-1:0] wdata_i
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	// no reset on the array itself, contents are whatever software left
	always @(posedge clock_i)
	begin
		if (ce_i)
		begin
			if (we_i)
				mem[waddr_i] <= wdata_i;
			rdata_o <= mem[raddr_i];
		end
	end
endmodule
`default_nettype wire

/* File: dv/srrx_checker.sv */
// assertions on the return and rotate executor ports
`timescale 1ns/10ps
`default_nettype none
`include "srrx_consts.vh"
module srrx_checker #(
	parameter PCW = 21
) (
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic [PCW-1:0] stack_top_value_i,
	input wire logic [PCW-1:0] pc_o,
	input wire logic stack_pop_o,
	input wire logic busy_o,
	input wire logic file_we_o,
	input wire logic [7:0] flags_o,
	input wire logic [7:0] file_wdata_o,
	input wire logic [7:0] pc_upper_latch_o,
	input wire logic [7:0] pc_high_latch_o,
	input wire logic [1:0] quarter_o
);
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!nrst_i);
	property p_pop_pc;
		stack_pop_o |-> pc_o == $past(stack_top_value_i);
	endproperty
	a_pop_pc: assert property (p_pop_pc) else $error("pc off");
	property p_pop_once;
		stack_pop_o |=> !stack_pop_o;
	endproperty
	a_pop_once: assert property (p_pop_once) else $error("pop long");
	property p_ret_len;
		stack_pop_o |-> busy_o [*4] ##1 !busy_o;
	endproperty
	a_ret_len: assert property (p_ret_len) else $error("ret len");
	property p_pop_late;
		stack_pop_o |-> $past(busy_o, 3);
	endproperty
	a_pop_late: assert property (p_pop_late) else $error("pop early");
	property p_we_once;
		file_we_o |=> !file_we_o;
	endproperty
	a_we_once: assert property (p_we_once) else $error("we long");
	property p_we_late;
		file_we_o |-> !busy_o && $past(busy_o) && $past(busy_o, 3)
			&& !$past(busy_o, 4);
	endproperty
	a_we_late: assert property (p_we_late) else $error("we time");
	property p_rot_flags;
		file_we_o |-> flags_o[`SRRX_FLAG_N] == file_wdata_o[7]
			&& flags_o[`SRRX_FLAG_Z] == (file_wdata_o == 8'h00);
	endproperty
	a_rot_flags: assert property (p_rot_flags) else $error("flags off");
	property p_latch;
		busy_o && $past(busy_o) |-> $stable({pc_upper_latch_o, pc_high_latch_o});
	endproperty
	a_latch: assert property (p_latch) else $error("latch moved");
	property p_freeze;
		!ce_i |=> $stable(quarter_o);
	endproperty
	a_freeze: assert property (p_freeze) else $error("not frozen");
endmodule
bind srrx_core srrx_checker #(
	.PCW(PCW)
) chk_u (
	.clock_i(clock_i),
	.nrst_i(nrst_i),
	.ce_i(ce_i),
	.stack_top_value_i(stack_top_value_i),
	.pc_o(pc_o),
	.stack_pop_o(stack_pop_o),
	.busy_o(busy_o),
	.file_we_o(file_we_o),
	.flags_o(flags_o),
	.file_wdata_o(file_wdata_o),
	.pc_upper_latch_o(pc_upper_latch_o),
	.pc_high_latch_o(pc_high_latch_o),
	.quarter_o(quarter_o)
);
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the return and rotate executor
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clock_i = 0, nrst_i = 0, ce_i = 1, instr_valid_i = 0;
	logic ext_set_en_i = 0, stack_pop_o, busy_o, file_we_o;
	logic [15:0] instr_i = 0;
	logic [11:0] index_base_i = 0, file_addr_o;
	logic [20:0] stack_top_value_i = 0, pc_o;
	logic [7:0] shadow_work_reg_i = 0, shadow_flags_reg_i = 0, f;
	logic [7:0] pc_upper_latch_i = 0, pc_high_latch_i = 0, ew = 0, ef = 0;
	logic [7:0] work_o, flags_o, pc_upper_latch_o, pc_high_latch_o;
	logic [7:0] file_wdata_o;
	logic [3:0] shadow_bank_select_i = 0, bank_select_register_o, eb = 0;
	logic [1:0] quarter_o;
	logic [31:0] r = 32'h073e;
	logic [48:0] e, rq[$];
	logic [11:0] aq[$];
	logic [36:0] oq[$];
	logic [7:0] mm [0:4095];
	logic pb = 0;
	int pr = 0;
	int bad_count = 0, check_count = 0;
	wire [48:0] seen = {pc_o, work_o, flags_o, bank_select_register_o,
		pc_upper_latch_o};
	wire [48:0] rot_seen = {12'h0, file_we_o, file_addr_o, file_wdata_o,
		work_o, flags_o};
	srrx_core dut_u (.*);
	always #12.5 clock_i = ~clock_i;
	function automatic logic [31:0] nx(input logic [31:0] x);
		repeat (8) x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
		return x;
	endfunction
	task automatic chk(input string n, input logic [48:0] s, v);
		check_count++;
		if (s !== v)
		begin
			bad_count++;
			$display("mismatch %s exp %h seen %h", n, v, s);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// offer at quarter 0 when idle, then move latches to catch stray writes
	task automatic run(input logic [15:0] op);
		int n;
		n = 0;
		while ((quarter_o !== 2'h0 || busy_o !== 1'b0) && n < 40)
		begin
			@(negedge clock_i);
			n++;
		end
		instr_i = op;
		instr_valid_i = 1;
		@(negedge clock_i);
		instr_valid_i = 0;
		r = nx(r);
		{pc_upper_latch_i, pc_high_latch_i} = r[15:0];
		while (busy_o === 1'b1 && n < 80)
		begin
			@(negedge clock_i);
			n++;
		end
	endtask
	// model one rotate: operand address, old byte, carry chain, destination
	task automatic rot(input logic d, input logic a);
		logic [11:0] ea;
		logic [7:0] ov, nv;
		ea = a ? {eb, f} : ext_set_en_i && f <= 8'h5f ?
			index_base_i + {4'h0, f} : {f < 8'h60 ? 4'h0 : 4'hf, f};
		ov = mm[ea];
		nv = {ov[6:0], ef[0]};
		ef[0] = ov[7];
		ef[4] = nv[7];
		ef[2] = nv == 8'h00;
		if (d)
		begin
			mm[ea] = nv;
			aq.push_back(ea);
		end
		else
			ew = nv;
		oq.push_back({d, ea, nv, ew, ef});
		run({6'h0d, d, a, f});
	endtask
	always @(negedge clock_i)
	begin
		if (stack_pop_o === 1'b1)
		begin
			pr++;
			e = rq.size() ? rq.pop_front() : 'x;
			chk("return", seen, e);
		end
		if (file_we_o === 1'b1)
		begin
			e = aq.size() ? {37'h0, aq.pop_front()} : 'x;
			chk("address", {37'h0, file_addr_o}, e);
		end
		// a fall after a pop closes a return, any other closes a rotate
		if (busy_o === 1'b0 && pb === 1'b1)
		begin
			if (pr > 0)
				pr--;
			else
			begin
				e = oq.size() ? {12'h0, oq.pop_front()} : 'x;
				chk("rotate", rot_seen, e);
			end
		end
		pb <= busy_o;
	end
	initial
	begin
		#100000;
		bad_count++;
		close_out;
	end
	initial
	begin
		// both copies start from the same random bytes
		for (int k = 0; k < 4096; k++)
		begin
			r = nx(r);
			mm[k] = r[7:0];
			dut_u.u_mem.mem[k] = r[7:0];
		end
		repeat (5) @(negedge clock_i);
		nrst_i = 1;
		for (int i = 0; i < 6; i++)
		begin
			r = nx(r);
			stack_top_value_i = r[20:0];
			r = nx(r);
			{shadow_work_reg_i, shadow_flags_reg_i, shadow_bank_select_i} = r[19:0];
			if (i[0])
				{ew, ef, eb} = r[19:0];
			rq.push_back({stack_top_value_i, ew, ef, eb, pc_upper_latch_i});
			run(16'h0012 | i[0]);
		end
		$display("returns done");
		// access, extended set and operand edge around the indexed limit
		for (int i = 0; i < 12; i++)
		begin
			r = nx(r);
			index_base_i = r[11:0];
			ext_set_en_i = i[1];
			f = i < 4 ? 8'h5f : i < 8 ? 8'h60 : r[23:16];
			rot(!i[2], i[0]);
		end
		rot(1'b0, 1'b0);
		repeat (8) @(negedge clock_i);
		$display("rotates done");
		ce_i = 0;
		repeat (4) @(negedge clock_i);
		ce_i = 1;
		chk("pending", rq.size() + aq.size() + oq.size(), 49'h0);
		close_out;
	end
endmodule
`default_nettype wire
